/* mfpc_board_model.sv */
module mfpc_board_model (
  // Clock
  input  wire logic pclk,
  // Device drive and resistors
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic pu_en,
  input  wire logic pd_en,
  // Board driver
  input  wire logic ext_en,
  input  wire logic ext_val,
  // Resolved wire level
  output logic      pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q;

  always_comb begin
    if (pin_oe) pin_in = pin_out;
    else if (ext_en) pin_in = ext_val;
    else if (pu_en) pin_in = 1'b1;
    else if (pd_en) pin_in = 1'b0;
    else pin_in = ~last_q;
  end

  // Floating wire keeps changing so a stale level never passes
  always_ff @(posedge pclk) last_q <= pin_in;
endmodule : mfpc_board_model

/* mfpc_pkg.sv */
package mfpc_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DB_TIME_NS    = 1000;
  localparam int unsigned DB_CYCLES     = (DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_PIN2    = 16'h0201;
  localparam logic [15:0] IDX_PIN3    = 16'h0202;
  localparam logic [15:0] IDX_PIN5    = 16'h0204;
  localparam logic [15:0] IDX_PIN6    = 16'h0205;
  localparam logic [15:0] IDX_CLKCTRL = 16'h0100;
  localparam logic [15:0] IDX_STATUS  = 16'h0101;

  // Reset values
  localparam logic [15:0] PIN23_RST   = 16'h0000;
  localparam logic [15:0] PIN56_RST   = 16'h8000;
  localparam logic [15:0] CLKCTRL_RST = 16'h0198;

  // Writable bits
  localparam logic [15:0] PIN23_WMASK   = 16'h045F;
  localparam logic [15:0] PIN56_WMASK   = 16'hF75F;
  localparam logic [15:0] CLKCTRL_WMASK = 16'h01FF;

  // Function codes and clock-out select
  localparam logic [4:0] FN_CLKOUT   = 5'h00;
  localparam logic [4:0] FN_LEVEL    = 5'h01;
  localparam logic [4:0] FN_RSV_A    = 5'h05;
  localparam logic [4:0] FN_RSV_B    = 5'h08;
  localparam logic [4:0] FN_RSV_C    = 5'h14;
  localparam logic [4:0] FN_RSV_FROM = 5'h17;
  localparam logic [1:0] SEL_GPIO    = 2'h1;

  // Pin control register layout
  typedef struct packed {
    logic       pin_direction;
    logic       pin_pullup_enable;
    logic       pin_pulldown_enable;
    logic       interrupt_polarity;
    logic       rsv11;
    logic       pin_polarity;
    logic       pin_output_type;
    logic       pin_debounce_enable;
    logic       rsv7;
    logic       pin_level;
    logic       rsv5;
    logic [4:0] pin_function_select;
  } mfpc_pin_cfg_t;

  // Clock control register layout
  typedef struct packed {
    logic [6:0] rsv;
    logic       clockout_b_output_enable;
    logic       clockout_b_divider;
    logic [1:0] clockout_b_select;
    logic       clockout_a_output_enable;
    logic       clockout_a_divider;
    logic [1:0] clockout_a_select;
    logic       clock_register_override;
  } mfpc_clk_cfg_t;

  // Drive of a two-way pin
  typedef struct packed {
    logic out;
    logic oe;
  } mfpc_drive_t;

endpackage : mfpc_pkg

/* mfpc_tb_top.sv */
module mfpc_tb_top
  import mfpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, clk_a_src, clk_b_src, rd_e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, func_src, rd_v, rnd, d;
  logic        pready, pslverr, pin_two, pin_three, ctrl_in;
  logic        five_in, five_out, five_oe, six_in, six_out, six_oe, ext_en, ext5, ext6;
  logic [1:0]  pu, pd, ev;
  logic [15:0] t_idx [5] = '{IDX_PIN2, IDX_PIN3, IDX_PIN5, IDX_PIN6, IDX_CLKCTRL};
  logic [15:0] t_rst [5] = '{PIN23_RST, PIN23_RST, PIN56_RST, PIN56_RST, CLKCTRL_RST};
  int          bad_count, n_compared;

  mfpc_top u_mfpc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_a_src(clk_a_src), .clk_b_src(clk_b_src), .func_src(func_src), .multi_pin_two(pin_two),
    .multi_pin_three(pin_three), .multi_pin_five_in(five_in), .multi_pin_five_out(five_out),
    .multi_pin_five_oe(five_oe), .multi_pin_six_in(six_in), .multi_pin_six_out(six_out),
    .multi_pin_six_oe(six_oe), .pullup_en(pu), .pulldown_en(pd), .clock_ctrl_in(ctrl_in), .gpio_event(ev));
  mfpc_board_model u_mfpc_board_model (.pclk(pclk), .pin_out(five_out), .pin_oe(five_oe), .pu_en(pu[0]),
    .pd_en(pd[0]), .ext_en(ext_en), .ext_val(ext5), .pin_in(five_in));
  mfpc_board_model u_mfpc_board_model_b (.pclk(pclk), .pin_out(six_out), .pin_oe(six_oe), .pu_en(pu[1]),
    .pd_en(pd[1]), .ext_en(ext_en), .ext_val(ext6), .pin_in(six_in));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic fn_out(input logic [4:0] c, input logic lvl, input logic [31:0] src);
    if (c == FN_LEVEL) return lvl;
    if (c == FN_CLKOUT || c == FN_RSV_A || c == FN_RSV_B || c == FN_RSV_C || c >= FN_RSV_FROM) return 1'b0;
    return src[c];
  endfunction : fn_out

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a transfer that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd, input int w);
    apb(1'b1, {idx[9:0], 2'b00}, wd);
    repeat (w) @(posedge pclk);
  endtask : wr

  task automatic rd(input logic [15:0] idx);
    apb(1'b0, {idx[9:0], 2'b00}, 32'h0000_0000);
  endtask : rd

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    complete_run();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, clk_b_src, ext5, ext6} = '0;
    {clk_a_src, ext_en} = 2'b11;
    func_src = 32'h0000_0000;
    rnd = 32'hd8de_1012;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    ext5 <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("pin_two", 1, pin_two);
    chk("pin_three", 0, pin_three);
    chk("ctrl_in", 1, ctrl_in);
    for (int i = 0; i < 5; i++) begin
      rd(t_idx[i]);
      chk("reset_val", {16'h0000, t_rst[i]}, rd_v);
    end
    apb(1'b0, 12'h0fc, 32'h0000_0000);
    chk("unmapped_err", 1, rd_e);
    // pin five refused while override is clear
    wr(IDX_PIN5, 32'h0000_0041, 3);
    rd(IDX_PIN5);
    chk("pin5_locked", {16'h0000, PIN56_RST}, rd_v);
    chk("five_oe", 0, five_oe);
    // override set before pin five or clock fields are touched
    wr(IDX_CLKCTRL, 32'h0000_0001, 0);
    wr(IDX_CLKCTRL, 32'h0000_0133, 0);
    rd(IDX_CLKCTRL);
    chk("clkctrl", 32'h0000_0133, rd_v);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wr(IDX_PIN2, 32'h0000_0001 | (rnd & 32'h0000_0440), 0);
      wr(IDX_PIN3, 32'h0000_0001 | ((rnd >> 1) & 32'h0000_0440), 3);
      chk("pin_two", rnd[6] ^ rnd[10], pin_two);
      chk("pin_three", rnd[7] ^ rnd[11], pin_three);
    end
    wr(IDX_PIN5, 32'h0000_0041, 3);
    chk("five_drive", 2'b11, {five_oe, five_out});
    for (int c = 0; c < 32; c++) begin
      rnd = lfsr(rnd);
      func_src <= rnd;
      d = (rnd & 32'h0000_0040) | c;
      wr(IDX_PIN6, d, 3);
      chk("six_fn", {1'b1, fn_out(c[4:0], rnd[6], rnd)}, {six_oe, six_out});
    end
    wr(IDX_PIN6, 32'h0000_0441, 3);
    chk("six_pol", 2'b10, {six_oe, six_out});
    for (int v = 0; v < 2; v++) begin
      wr(IDX_PIN6, 32'h0000_0201 | (v << 6), 3);
      chk("six_od", {~v[0], 1'b0}, {six_oe, six_out});
    end
    wr(IDX_PIN6, 32'h0000_E000, 3);
    chk("pull_both", 2'b00, {pu[1], pd[1]});
    wr(IDX_PIN6, 32'h0000_C000, 3);
    chk("pull_up", 2'b10, {pu[1], pd[1]});
    // input direction paired with level function
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      ext6 <= rnd[0];
      wr(IDX_PIN6, 32'h0000_8001 | (rnd[1] << 12), 4);
      rd(IDX_PIN6);
      chk("six_lvl", rnd[0], rd_v[6]);
      chk("six_event", rnd[0] == rnd[1], ev[1]);
    end
    ext6 <= 1'b1;
    wr(IDX_PIN6, 32'h0000_9101, DB_CYCLES + 10);
    chk("db_set", 1, ev[1]);
    ext6 <= 1'b0;
    repeat (DB_CYCLES / 2) @(posedge pclk);
    chk("db_hold", 1, ev[1]);
    repeat (DB_CYCLES) @(posedge pclk);
    chk("db_move", 0, ev[1]);
    complete_run();
  end
endmodule : mfpc_tb_top

/* mfpc_top.sv */
// Summary of operation
// R01: Two output-only pins (two, three) and two bidirectional pins (five, six).
// R02: Outside party holds pin five at a defined level during start-up.
// R03: Pin five general use and clock field writes need override set.
// R04: Software leaves pin five register at reset while override is clear.
// R05: Pin five held at defined level whenever it is an input.
// R06: Pin two is clock out unless override, select 01, divider 0, enable 1.
// R07: Pin three is loop clock unless override, select 01, divider 0, enable 1.
// R08: Software sets override before writing clock-out fields.
// R09: Software keeps pin five/six direction consistent with function.
// R10: Output-type bit picks push-pull or open-drain drive on pins five, six.
// R11: Input pins five, six raise interrupt event at chosen polarity.
// R12: Debounce enable filters the input used for interrupt events.
// R13: Pull-up and pull-down switch resistors; both set disables both.
// R14: Polarity bit 10 inverts the pin output when set; reset clear.
// R15: Output direction with function 01h drives the written level.
// R16: Input direction with function 01h reads back the pin level.
// R17: Level bit 6 of pins two, three is write-only; reads undefined.
// R18: Function select bits 4:0 decode the lower signal codes.
// R19: Function select decodes upper codes; 10111 to 11111 reserved.
// R20: Clock output on pins two, three only via clock-out select.
// R21: Pin five pull-up at bit 14, pull-down at bit 13, reset clear.
// R22: Debounce accepts a change only after a fixed stable period.
module mfpc_top
  import mfpc_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Clock sources and internal status signals, indexed by function code
  input  wire logic              clk_a_src,
  input  wire logic              clk_b_src,
  input  wire logic [31:0]       func_src,
  // Output-only pins
  output logic                   multi_pin_two,
  output logic                   multi_pin_three,
  // Bidirectional pins
  input  wire logic              multi_pin_five_in,
  output logic                   multi_pin_five_out,
  output logic                   multi_pin_five_oe,
  input  wire logic              multi_pin_six_in,
  output logic                   multi_pin_six_out,
  output logic                   multi_pin_six_oe,
  // Resistor controls, bit 0 pin five, bit 1 pin six
  output logic      [1:0]        pullup_en,
  output logic      [1:0]        pulldown_en,
  // To clocking control and interrupt logic
  output logic                   clock_ctrl_in,
  output logic      [1:0]        gpio_event
);

  localparam int unsigned CNT_W = $clog2(DB_CYCLES + 1);
  localparam logic [CNT_W-1:0] DB_LAST = CNT_W'(DB_CYCLES - 1);

  if (ADDR_W < 12 || ADDR_W > 18) begin : g_chk
    $error("mfpc_top: ADDR_W must be 12 to 18");
  end

  function automatic logic [15:0] reg_index(input logic [ADDR_W-1:0] a);
    return 16'(a[ADDR_W-1:2]);
  endfunction : reg_index

  // Signal chosen by a function code; reserved and clock-out codes give 0
  function automatic logic fn_value(input logic [4:0] fn, input logic lvl, input logic [31:0] src);
    logic v;
    v = src[fn];
    if (fn == FN_LEVEL) begin
      v = lvl;
    end else if (fn == FN_CLKOUT || fn == FN_RSV_A || fn == FN_RSV_B || fn == FN_RSV_C || fn >= FN_RSV_FROM) begin
      v = 1'b0;
    end
    return v;
  endfunction : fn_value

  mfpc_pin_cfg_t pin2_q, pin3_q, pin5_q, pin6_q;
  mfpc_clk_cfg_t clk_q;
  logic [3:0]    sync1_q, sync2_q;
  logic [1:0]    stable_q;
  logic [CNT_W-1:0] cnt_q [2];
  logic [31:0]   prdata_q;
  logic          pready_q, pslverr_q;
  logic          two_q, three_q, ctrl_q;
  mfpc_drive_t   drv5_q, drv6_q;
  logic [1:0]    pu_q, pd_q, event_q;

  logic          setup, wr_en, mapped;
  logic [15:0]   idx;
  logic [1:0]    pin_in;
  logic [31:0]   rd_d;
  logic          gp_a, gp_b;
  mfpc_drive_t   drv5_d, drv6_d;

  assign setup  = psel & ~penable;
  assign idx    = reg_index(paddr);
  assign mapped = idx == IDX_PIN2 || idx == IDX_PIN3 || idx == IDX_PIN5 || idx == IDX_PIN6 ||
                  idx == IDX_CLKCTRL || idx == IDX_STATUS;
  assign wr_en  = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign pin_in = sync2_q[1:0];

  // Pin inputs and clock sources cross in through two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {clk_b_src, clk_a_src, multi_pin_six_in, multi_pin_five_in};
      sync2_q <= sync1_q;
    end
  end

  // APB handshake: answer registered one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_q <= rd_d;
      end
    end
  end

  // Read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    case (idx)
      IDX_PIN2: begin
        rd_d[15:0] = pin2_q;
        // R17 level write-only
        rd_d[6] = 1'b0;
      end
      IDX_PIN3: begin
        rd_d[15:0] = pin3_q;
        // R17 level write-only
        rd_d[6] = 1'b0;
      end
      IDX_PIN5: begin
        rd_d[15:0] = pin5_q;
        // R16 input readback
        if (pin5_q.pin_direction && pin5_q.pin_function_select == FN_LEVEL) begin
          rd_d[6] = pin_in[0];
        end
      end
      IDX_PIN6: begin
        rd_d[15:0] = pin6_q;
        // R16 input readback
        if (pin6_q.pin_direction && pin6_q.pin_function_select == FN_LEVEL) begin
          rd_d[6] = pin_in[1];
        end
      end
      IDX_CLKCTRL: rd_d[15:0] = clk_q;
      IDX_STATUS:  rd_d[5:0] = {event_q, stable_q, pin_in};
      default:     rd_d = 32'h0000_0000;
    endcase
  end

  // Clock control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= mfpc_clk_cfg_t'(CLKCTRL_RST);
    end else if (wr_en && idx == IDX_CLKCTRL) begin
      // R03 clock fields locked until override already set
      if (clk_q.clock_register_override) begin
        clk_q <= mfpc_clk_cfg_t'(pwdata[15:0] & CLKCTRL_WMASK);
      end else begin
        clk_q.clock_register_override <= pwdata[0];
      end
    end
  end

  // Pin control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // R14 R21 reset values
      pin2_q <= mfpc_pin_cfg_t'(PIN23_RST);
      pin3_q <= mfpc_pin_cfg_t'(PIN23_RST);
      pin5_q <= mfpc_pin_cfg_t'(PIN56_RST);
      pin6_q <= mfpc_pin_cfg_t'(PIN56_RST);
    end else if (wr_en) begin
      if (idx == IDX_PIN2) begin
        pin2_q <= mfpc_pin_cfg_t'(pwdata[15:0] & PIN23_WMASK);
      end
      if (idx == IDX_PIN3) begin
        pin3_q <= mfpc_pin_cfg_t'(pwdata[15:0] & PIN23_WMASK);
      end
      // R03 pin five writes ignored while clocking owns it
      if (idx == IDX_PIN5 && clk_q.clock_register_override) begin
        pin5_q <= mfpc_pin_cfg_t'(pwdata[15:0] & PIN56_WMASK);
      end
      if (idx == IDX_PIN6) begin
        pin6_q <= mfpc_pin_cfg_t'(pwdata[15:0] & PIN56_WMASK);
      end
    end
  end

  // R06 R07 general-purpose mode of the output-only pins
  // Divider left set keeps the pin on its clock, as it is after reset
  assign gp_a = clk_q.clock_register_override && clk_q.clockout_a_select == SEL_GPIO &&
                !clk_q.clockout_a_divider && clk_q.clockout_a_output_enable;
  assign gp_b = clk_q.clock_register_override && clk_q.clockout_b_select == SEL_GPIO &&
                !clk_q.clockout_b_divider && clk_q.clockout_b_output_enable;

  // Output-only pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      two_q   <= 1'b0;
      three_q <= 1'b0;
    end else begin
      // R15 R18 R19 R14 selected signal, then polarity
      if (gp_a) begin
        two_q <= fn_value(pin2_q.pin_function_select, pin2_q.pin_level, func_src) ^ pin2_q.pin_polarity;
      end else begin
        // R20 clock reaches the pin only via select
        two_q <= clk_q.clockout_a_output_enable & sync2_q[2];
      end
      if (gp_b) begin
        three_q <= fn_value(pin3_q.pin_function_select, pin3_q.pin_level, func_src) ^ pin3_q.pin_polarity;
      end else begin
        three_q <= clk_q.clockout_b_output_enable & sync2_q[3];
      end
    end
  end

  // Bidirectional drive
  always_comb begin
    logic v5;
    logic v6;
    v5 = fn_value(pin5_q.pin_function_select, pin5_q.pin_level, func_src) ^ pin5_q.pin_polarity;
    v6 = fn_value(pin6_q.pin_function_select, pin6_q.pin_level, func_src) ^ pin6_q.pin_polarity;
    drv5_d = '{out: 1'b0, oe: 1'b0};
    drv6_d = '{out: 1'b0, oe: 1'b0};
    // R10 push-pull or open-drain
    // Open drain only ever pulls low; the board's resistor makes the high
    if (!pin5_q.pin_direction && clk_q.clock_register_override) begin
      if (pin5_q.pin_output_type) begin
        drv5_d.out = 1'b0;
        drv5_d.oe  = ~v5;
      end else begin
        drv5_d.out = v5;
        drv5_d.oe  = 1'b1;
      end
    end
    if (!pin6_q.pin_direction) begin
      if (pin6_q.pin_output_type) begin
        drv6_d.out = 1'b0;
        drv6_d.oe  = ~v6;
      end else begin
        drv6_d.out = v6;
        drv6_d.oe  = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv5_q <= '{out: 1'b0, oe: 1'b0};
      drv6_q <= '{out: 1'b0, oe: 1'b0};
      ctrl_q <= 1'b0;
    end else begin
      drv5_q <= drv5_d;
      drv6_q <= drv6_d;
      ctrl_q <= pin_in[0];
    end
  end

  // R13 R21 both set disables both resistors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_q <= 2'h0;
      pd_q <= 2'h0;
    end else begin
      pu_q <= {pin6_q.pin_pullup_enable & ~pin6_q.pin_pulldown_enable,
               pin5_q.pin_pullup_enable & ~pin5_q.pin_pulldown_enable};
      pd_q <= {pin6_q.pin_pulldown_enable & ~pin6_q.pin_pullup_enable,
               pin5_q.pin_pulldown_enable & ~pin5_q.pin_pullup_enable};
    end
  end

  // R22 stable-period filter
  // Counter restarts whenever the input falls back to the accepted level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q <= 2'h0;
      cnt_q[0] <= '0;
      cnt_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pin_in[i] == stable_q[i]) begin
          cnt_q[i] <= '0;
        end else if (cnt_q[i] == DB_LAST) begin
          stable_q[i] <= pin_in[i];
          cnt_q[i]    <= '0;
        end else begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
        end
      end
    end
  end

  // R11 R12 event level from raw or filtered input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q <= 2'h0;
    end else begin
      event_q[0] <= pin5_q.pin_direction & clk_q.clock_register_override &
                    ((pin5_q.pin_debounce_enable ? stable_q[0] : pin_in[0]) == pin5_q.interrupt_polarity);
      event_q[1] <= pin6_q.pin_direction &
                    ((pin6_q.pin_debounce_enable ? stable_q[1] : pin_in[1]) == pin6_q.interrupt_polarity);
    end
  end

  // R01 pins two, three output-only; five, six two-way
  // Every output leaves straight from a flop
  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign multi_pin_two      = two_q;
  assign multi_pin_three    = three_q;
  assign multi_pin_five_out = drv5_q.out;
  assign multi_pin_five_oe  = drv5_q.oe;
  assign multi_pin_six_out  = drv6_q.out;
  assign multi_pin_six_oe   = drv6_q.oe;
  assign pullup_en          = pu_q;
  assign pulldown_en        = pd_q;
  assign clock_ctrl_in      = ctrl_q;
  assign gpio_event         = event_q;

endmodule : mfpc_top

/* mfpc_top_monitor.sv */
module mfpc_top_monitor
  import mfpc_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Pins
  input wire logic              multi_pin_five_in,
  input wire logic              clock_ctrl_in,
  input wire logic [1:0]        pullup_en,
  input wire logic [1:0]        pulldown_en
);
  logic mapped;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign mapped = 16'(paddr[ADDR_W-1:2]) inside {IDX_PIN2, IDX_PIN3, IDX_PIN5, IDX_PIN6,
                                                 IDX_CLKCTRL, IDX_STATUS};

  setup_ready_a: assert property ((psel && !penable) |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property ((psel && !penable && !mapped) |=> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property ((psel && !penable && mapped) |=> !pslverr)
    else $error("mapped access refused");
  upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  pull_excl_a: assert property ((pullup_en & pulldown_en) == 2'b00)
    else $error("both resistors enabled");
  ctrl_follow_a: assert property ($stable(multi_pin_five_in) [*4] |-> clock_ctrl_in == multi_pin_five_in)
    else $error("clock control input lags pin");
endmodule : mfpc_top_monitor

bind mfpc_top mfpc_top_monitor #(.ADDR_W(ADDR_W)) u_mfpc_top_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .multi_pin_five_in(multi_pin_five_in),
  .clock_ctrl_in(clock_ctrl_in), .pullup_en(pullup_en), .pulldown_en(pulldown_en)
);
